/* logic/adcri_pkg.sv */
// Purpose: Shared constants for the converter result and interrupt registers
// Assumes: 32-bit register port, byte offsets
// Notes: Offsets are byte addresses

package adcri_pkg;
  localparam int ADCRI_NCH = 8;
  localparam int ADCRI_RES_W = 10;
  localparam int ADCRI_AW = 8;
  localparam logic [7:0] ADCRI_OFF_CH_ON_SET = 8'h10;
  localparam logic [7:0] ADCRI_OFF_CH_ON_CLR = 8'h14;
  localparam logic [7:0] ADCRI_OFF_CH_ON_STAT = 8'h18;
  localparam logic [7:0] ADCRI_OFF_FLAGS = 8'h1C;
  localparam logic [7:0] ADCRI_OFF_LAST = 8'h20;
  localparam logic [7:0] ADCRI_OFF_IRQ_SET = 8'h24;
  localparam logic [7:0] ADCRI_OFF_IRQ_CLR = 8'h28;
  localparam logic [7:0] ADCRI_OFF_IRQ_MASK = 8'h2C;
  localparam logic [7:0] ADCRI_OFF_CH_RES0 = 8'h30;
  localparam logic [7:0] ADCRI_OFF_VERSION = 8'hFC;
  // Flag register field positions
  localparam int ADCRI_BIT_OVR0 = 8;
  localparam int ADCRI_BIT_RESULT_READY_FLAG = 16;
  localparam int ADCRI_BIT_GOVR = 17;
  localparam int ADCRI_BIT_RECEIVE_END_FLAG = 18;
  localparam int ADCRI_BIT_RXBUF = 19;
  localparam int ADCRI_FLAG_W = 20;
  localparam logic [31:0] ADCRI_RESET_WORD = 32'h00000000;
  // Arbitrary identity values
  localparam logic [11:0] ADCRI_VERSION_NUM = 12'h001;
  localparam logic [3:0] ADCRI_VARIANT_NUM = 4'h0;
  localparam int ADCRI_NTRIG = 6;
endpackage

/* logic/adcri_res_if.sv */
// Purpose: Carries result store write and read ports
// Assumes: One clock domain
// Notes: Used between the top and the result memory
`timescale 1ns/1ps

interface adcri_res_if #(parameter int NCH = 8, parameter int W = 10);
  logic wr_en;
  logic [$clog2(NCH)-1:0] wr_idx;
  logic [W-1:0] wr_data;
  logic [$clog2(NCH)-1:0] rd_idx;
  logic [W-1:0] rd_data;
  modport owner (output wr_en, output wr_idx, output wr_data, output rd_idx, input rd_data);
  modport store (input wr_en, input wr_idx, input wr_data, input rd_idx, output rd_data);
endinterface

/* logic/adcri_res_mem.sv */
// Purpose: Per-channel result store with registered read data
// Assumes: Write and read in the same clock
// Notes: Contents start at zero after reset
`timescale 1ns/1ps

module adcri_res_mem #(
  parameter int NCH = 8,
  parameter int W = 10
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  adcri_res_if.store port
);
  logic [W-1:0] mem [NCH];

  // Storage and registered read
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      for (int i = 0; i < NCH; i++) mem[i] <= '0;
      port.rd_data <= '0;
    end else begin
      if (port.wr_en) mem[port.wr_idx] <= port.wr_data;
      port.rd_data <= mem[port.rd_idx];
    end
  end
endmodule

/* logic/adcri_top.sv */
// Purpose: Result, flag and interrupt registers of an eight-channel converter
// Assumes: Sequencer gives one-cycle done pulses with channel and result
// Notes: Read data appear the cycle after the read strobe
// How it works
// - A channel's done flag is set when that channel's conversion completes.
// - Reading the channel's result register or the last result clears the done flag.
// - A done flag reads one only while its channel is enabled and its conversion done.
// - Every conversion loads its 10-bit result into the last result register, upper bits zero.
// - A channel result register loads only when that channel is enabled.
// - Writing one to the enable-set register sets the matching mask bit.
// - Writing one to the enable-clear register clears the matching mask bit.
// - Zero bits in enable-set or enable-clear leave the mask alone.
// - The mask register reads back each enabled source in the flag layout.
// - The version register shows a 12-bit number and a 4-bit variant.
// - Eight analog channels are implemented.
// - Trigger sources 0 to 5 are timer outputs A and B of timer channels 0 to 2.
// - The data-ready flag sets on a new last result and clears when it is read.
// - Overrun flags set on overrun and clear when the flag register is read.
// - A channel is enabled by channel-on-set and disabled by channel-on-clear.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps

module adcri_top #(
  parameter int NCH = adcri_pkg::ADCRI_NCH,
  parameter int RES_W = adcri_pkg::ADCRI_RES_W
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [adcri_pkg::ADCRI_AW-1:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output logic irq_o,
  input wire logic conv_done_i,
  input wire logic [2:0] conv_ch_i,
  input wire logic [9:0] conv_data_i,
  input wire logic [7:0] ovr_i,
  input wire logic govr_i,
  input wire logic receive_end_flag_i,
  input wire logic rxbuf_i,
  input wire logic [2:0] timer_output_a_i,
  input wire logic [2:0] timer_output_b_i,
  output logic [5:0] hw_trig_o,
  output logic [7:0] channel_on_o
);
  import adcri_pkg::*;

  logic [7:0] channel_on_status;
  logic [7:0] conv_done_flag;
  logic [7:0] channel_overrun_flag;
  logic result_ready_flag;
  logic any_overrun_flag;
  logic [ADCRI_FLAG_W-1:0] irq_mask;
  logic [9:0] last_result_value;
  logic [31:0] rdata_q;
  logic rd_ch_pend;
  logic [31:0] next_rdata;
  logic [1:0] receive_end_flag_s;
  logic [1:0] rxbuf_s;
  logic [2:0] ta_s1, ta_s2, tb_s1, tb_s2;

  adcri_res_if #(.NCH(NCH), .W(RES_W)) res_bus ();

  adcri_res_mem #(.NCH(NCH), .W(RES_W)) u_mem (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .port(res_bus.store)
  );

  // Register decode
  wire wr_on_set = wr_i && addr_i == ADCRI_OFF_CH_ON_SET;
  wire wr_on_clr = wr_i && addr_i == ADCRI_OFF_CH_ON_CLR;
  wire wr_irq_set = wr_i && addr_i == ADCRI_OFF_IRQ_SET;
  wire wr_irq_clr = wr_i && addr_i == ADCRI_OFF_IRQ_CLR;
  wire rd_flags = rd_i && addr_i == ADCRI_OFF_FLAGS;
  wire rd_last = rd_i && addr_i == ADCRI_OFF_LAST;
  wire rd_chres = rd_i && addr_i >= ADCRI_OFF_CH_RES0
                  && addr_i < ADCRI_OFF_CH_RES0 + 8'h20 && addr_i[1:0] == 2'b00;
  wire [2:0] chres_idx = 3'((addr_i - ADCRI_OFF_CH_RES0) >> 2);

  // Conversion completion events
  wire [7:0] conv_hit = conv_done_i ? (8'h01 << conv_ch_i) : 8'h00;
  wire ch_enabled_hit = |(conv_hit & channel_on_status);
  wire [7:0] rd_clear = (rd_chres ? (8'h01 << chres_idx) : 8'h00) | {8{rd_last}};

  // Flag word in register layout
  wire [7:0] done_view = conv_done_flag & channel_on_status;
  wire [ADCRI_FLAG_W-1:0] flag_word = {rxbuf_s[1], receive_end_flag_s[1], any_overrun_flag,
                                       result_ready_flag, channel_overrun_flag, done_view};
  wire irq_any = |(flag_word & irq_mask);

  // Mask update; a zero bit in either word leaves its mask bit as it is,
  // and only one of the two words can be written in a cycle
  wire [ADCRI_FLAG_W-1:0] wdata_lo = wdata_i[ADCRI_FLAG_W-1:0];
  wire [ADCRI_FLAG_W-1:0] mask_set_bits = wdata_lo & {ADCRI_FLAG_W{wr_irq_set}};
  wire [ADCRI_FLAG_W-1:0] mask_clr_bits = wdata_lo & {ADCRI_FLAG_W{wr_irq_clr}};
  wire [ADCRI_FLAG_W-1:0] next_mask = (irq_mask | mask_set_bits) & ~mask_clr_bits;

  // Result store hookup
  assign res_bus.wr_en = ch_enabled_hit;
  assign res_bus.wr_idx = conv_ch_i;
  assign res_bus.wr_data = conv_data_i;
  assign res_bus.rd_idx = chres_idx;

  // Read mux, data for the next cycle
  always_comb begin
    next_rdata = ADCRI_RESET_WORD;
    case (addr_i)
      ADCRI_OFF_CH_ON_STAT: next_rdata = {24'h000000, channel_on_status};
      ADCRI_OFF_FLAGS: next_rdata = {12'h000, flag_word};
      ADCRI_OFF_LAST: next_rdata = {22'h000000, last_result_value};
      ADCRI_OFF_IRQ_MASK: next_rdata = {12'h000, irq_mask};
      ADCRI_OFF_VERSION: next_rdata = {12'h000, ADCRI_VARIANT_NUM, 4'h0,
                                       ADCRI_VERSION_NUM};
      default: next_rdata = ADCRI_RESET_WORD;
    endcase
  end

  // Pin synchronisers
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      receive_end_flag_s <= 2'b00;
      rxbuf_s <= 2'b00;
      ta_s1 <= 3'h0;
      ta_s2 <= 3'h0;
      tb_s1 <= 3'h0;
      tb_s2 <= 3'h0;
    end else begin
      receive_end_flag_s <= {receive_end_flag_s[0], receive_end_flag_i};
      rxbuf_s <= {rxbuf_s[0], rxbuf_i};
      ta_s1 <= timer_output_a_i;
      ta_s2 <= ta_s1;
      tb_s1 <= timer_output_b_i;
      tb_s2 <= tb_s1;
    end
  end

  // Trigger routing, timer output A on even and B on odd trigger numbers
  wire [5:0] next_trig;
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_trig
      assign next_trig[2*g] = ta_s2[g];
      assign next_trig[2*g+1] = tb_s2[g];
    end
  endgenerate

  // Trigger outputs, registered after the synchronisers;
  // one process owns the whole vector
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) hw_trig_o <= 6'h00;
    else hw_trig_o <= next_trig;
  end

  // Channel enable state
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) channel_on_status <= 8'h00;
    else channel_on_status <= (channel_on_status | (wr_on_set ? wdata_i[7:0] : 8'h00))
                              & ~(wr_on_clr ? wdata_i[7:0] : 8'h00);
  end

  // Done and overrun flags; a set wins over a clear in the same cycle
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      conv_done_flag <= 8'h00;
      channel_overrun_flag <= 8'h00;
      any_overrun_flag <= 1'b0;
      result_ready_flag <= 1'b0;
    end else begin
      conv_done_flag <= (conv_done_flag & ~rd_clear) | conv_hit;
      channel_overrun_flag <= (channel_overrun_flag & {8{~rd_flags}}) | ovr_i;
      any_overrun_flag <= (any_overrun_flag & ~rd_flags) | govr_i;
      result_ready_flag <= (result_ready_flag & ~rd_last) | conv_done_i;
    end
  end

  // Last result and mask
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      last_result_value <= 10'h000;
      irq_mask <= '0;
    end else begin
      if (conv_done_i) last_result_value <= conv_data_i;
      irq_mask <= next_mask;
    end
  end

  // Registered read data and outputs
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rdata_q <= ADCRI_RESET_WORD;
      rd_ch_pend <= 1'b0;
      irq_o <= 1'b0;
      channel_on_o <= 8'h00;
    end else begin
      rd_ch_pend <= rd_chres;
      rdata_q <= rd_i ? next_rdata : ADCRI_RESET_WORD;
      irq_o <= irq_any;
      channel_on_o <= channel_on_status;
    end
  end

  // Read data; channel results come from the store's own read register, which
  // would be a cycle late behind a second register, so the two are selected here
  assign rdata_o = rd_ch_pend ? {22'h000000, res_bus.rd_data} : rdata_q;

  // Register behaviour checks, all idle while reset is high
  // Done flags set on completion
  a_done_sets: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    conv_done_i |=> conv_done_flag[$past(conv_ch_i)])
    else $error("done flag not set");

  // A last-result read clears every done flag and the data-ready flag
  a_last_clears: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    rd_last && !conv_done_i |=> conv_done_flag == 8'h00 && !result_ready_flag)
    else $error("last read did not clear");

  // A channel result read clears that channel's done flag
  a_chres_clear: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    rd_chres && !conv_done_i |=> !conv_done_flag[$past(chres_idx)])
    else $error("channel read did not clear");

  // A disabled channel never shows a done flag
  a_done_view: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (done_view & ~channel_on_status) == 8'h00)
    else $error("done shown while off");

  // The same holds for the flag word that software reads
  a_flags_read: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    rd_flags |=> (rdata_o[7:0] & ~$past(channel_on_status)) == 8'h00)
    else $error("done read while off");

  // Last result loads on every completion
  a_last_load: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    conv_done_i |=> last_result_value == $past(conv_data_i))
    else $error("last not loaded");

  // Last result holds between completions
  a_last_hold: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !conv_done_i |=> $stable(last_result_value))
    else $error("last changed");

  // Last result reads back with the upper bits zero
  a_last_read: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    rd_last |=> rdata_o == {22'h000000, $past(last_result_value)})
    else $error("last read wrong");

  // The store is written only for an enabled channel
  a_chres_gate: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    res_bus.wr_en |-> conv_done_i && channel_on_status[conv_ch_i])
    else $error("result stored for disabled channel");

  // Channel result reads carry zero upper bits
  a_chres_upper: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    rd_chres |=> rdata_o[31:10] == 22'h000000)
    else $error("channel read upper bits set");

  // Enable-set word sets its one bits in the mask
  a_mask_set: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    wr_irq_set |=> (irq_mask & $past(wdata_lo)) == $past(wdata_lo))
    else $error("mask not set");

  // Enable-clear word clears its one bits in the mask
  a_mask_clr: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    wr_irq_clr |=> (irq_mask & $past(wdata_lo)) == '0)
    else $error("mask not cleared");

  // Without either write the mask stays put
  a_mask_keep: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !wr_irq_set && !wr_irq_clr |=> $stable(irq_mask))
    else $error("mask moved");

  // Mask reads back in the flag layout
  a_mask_read: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    rd_i && addr_i == ADCRI_OFF_IRQ_MASK |=> rdata_o == {12'h000, $past(irq_mask)})
    else $error("mask read wrong");

  // Version word shows the number and the variant fields
  a_version_read: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    rd_i && addr_i == ADCRI_OFF_VERSION |=> rdata_o[11:0] == ADCRI_VERSION_NUM
                                          && rdata_o[19:16] == ADCRI_VARIANT_NUM)
    else $error("version read wrong");

  // All eight channel states reach the output
  a_chan_out: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    1'b1 |=> channel_on_o == $past(channel_on_status))
    else $error("channel output wrong");

  // Triggers follow the synchronised timer outputs, A even and B odd
  a_trig_route: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    1'b1 |=> hw_trig_o == {$past(tb_s2[2]), $past(ta_s2[2]), $past(tb_s2[1]),
                           $past(ta_s2[1]), $past(tb_s2[0]), $past(ta_s2[0])})
    else $error("trigger routing wrong");

  // Data ready follows every completion
  a_ready_sets: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    conv_done_i |=> result_ready_flag)
    else $error("ready not set");

  // Channel overruns set their flags
  a_ovr_sets: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    ovr_i != 8'h00 |=> (channel_overrun_flag & $past(ovr_i)) == $past(ovr_i))
    else $error("overrun not set");

  // A flag read clears the channel overruns
  a_ovr_clear: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    rd_flags && ovr_i == 8'h00 |=> channel_overrun_flag == 8'h00)
    else $error("overrun not cleared");

  // General overrun sets
  a_govr_sets: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    govr_i |=> any_overrun_flag)
    else $error("general overrun not set");

  // A flag read clears the general overrun
  a_govr_clear: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    rd_flags && !govr_i |=> !any_overrun_flag)
    else $error("general overrun not cleared");

  // Channel-on-set turns channels on
  a_chan_on: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    wr_on_set |=> (channel_on_status & $past(wdata_i[7:0])) == $past(wdata_i[7:0]))
    else $error("channel not enabled");

  // Channel-on-clear turns channels off
  a_chan_off: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    wr_on_clr |=> (channel_on_status & $past(wdata_i[7:0])) == 8'h00)
    else $error("channel not disabled");

  // Interrupt rises for a pending unmasked flag
  a_irq_level: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    irq_any |=> irq_o)
    else $error("irq missing");

  // Interrupt drops once no unmasked flag is pending
  a_irq_drop: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !irq_any |=> !irq_o)
    else $error("irq stuck");

  // Main scenarios
  c_conv: cover property (@(posedge clk_sys_i) conv_done_i && ch_enabled_hit);
  c_irq: cover property (@(posedge clk_sys_i) irq_o);
  c_chres: cover property (@(posedge clk_sys_i) rd_chres ##1 rd_ch_pend);
  c_ovr: cover property (@(posedge clk_sys_i) (|channel_overrun_flag) && rd_flags);
  c_trig: cover property (@(posedge clk_sys_i) hw_trig_o != 6'h00);
endmodule

/* test/adcri_top_test.sv */
// Purpose: Self-checking bench for the converter result and interrupt registers
// Assumes: Read data stand in the cycle after the read strobe
// Notes: Each done pulse is followed by two idle cycles before flags are read
`timescale 1ns/1ps

module adcri_top_test;
  import adcri_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic irq_o;
  logic conv_done_i = 1'b0;
  logic [2:0] conv_ch_i = 3'h0;
  logic [9:0] conv_data_i = 10'h000;
  logic [7:0] ovr_i = 8'h00;
  logic govr_i = 1'b0;
  logic receive_end_flag_i = 1'b0;
  logic rxbuf_i = 1'b0;
  logic [2:0] timer_output_a_i = 3'h0;
  logic [2:0] timer_output_b_i = 3'h0;
  logic [5:0] hw_trig_o;
  logic [7:0] channel_on_o;
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;

  // Clock at 20 MHz
  always #25 clk_sys_i = ~clk_sys_i;

  adcri_top u_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .conv_done_i(conv_done_i),
    .conv_ch_i(conv_ch_i), .conv_data_i(conv_data_i), .ovr_i(ovr_i), .govr_i(govr_i),
    .receive_end_flag_i(receive_end_flag_i), .rxbuf_i(rxbuf_i), .timer_output_a_i(timer_output_a_i),
    .timer_output_b_i(timer_output_b_i), .hw_trig_o(hw_trig_o), .channel_on_o(channel_on_o));

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check_word(input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  // One-cycle write strobe
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask

  // One-cycle read strobe, data taken in the following cycle
  task automatic reg_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1 check_word(exp, rdata_o);
  endtask

  task automatic irq_chk(input logic exp);
    @(posedge clk_sys_i);
    #1 check_word({31'h0, exp}, {31'h0, irq_o});
  endtask

  // Single done pulse from the sequencer
  task automatic conv(input logic [2:0] ch, input logic [9:0] d);
    @(posedge clk_sys_i);
    conv_done_i <= 1'b1;
    conv_ch_i <= ch;
    conv_data_i <= d;
    @(posedge clk_sys_i);
    conv_done_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask

  // Hang guard
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      report_and_stop();
    end
  end

  initial begin
    repeat (3) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    reg_chk(ADCRI_OFF_LAST, 32'h0);
    reg_chk(ADCRI_OFF_IRQ_MASK, 32'h0);
    reg_chk(ADCRI_OFF_VERSION, {12'h0, ADCRI_VARIANT_NUM, 4'h0, ADCRI_VERSION_NUM});
    $display("test reset values done");
    reg_wr(ADCRI_OFF_CH_ON_SET, 32'h85);
    reg_wr(ADCRI_OFF_CH_ON_CLR, 32'h01);
    reg_chk(ADCRI_OFF_CH_ON_STAT, 32'h84);
    check_word(32'h84, {24'h0, channel_on_o});
    $display("test channel enables done");
    conv(3'd7, 10'h3A5);
    reg_chk(ADCRI_OFF_FLAGS, 32'h00010080);
    reg_chk(ADCRI_OFF_CH_RES0 + 8'h1C, 32'h3A5);
    reg_chk(ADCRI_OFF_FLAGS, 32'h00010000);
    reg_chk(ADCRI_OFF_LAST, 32'h3A5);
    reg_chk(ADCRI_OFF_FLAGS, 32'h0);
    conv(3'd1, 10'h155);
    reg_chk(ADCRI_OFF_FLAGS, 32'h00010000);
    reg_chk(ADCRI_OFF_CH_RES0 + 8'h04, 32'h0);
    reg_chk(ADCRI_OFF_LAST, 32'h155);
    reg_chk(ADCRI_OFF_CH_RES0 + 8'h1C, 32'h3A5);
    $display("test results and flags done");
    reg_wr(ADCRI_OFF_IRQ_SET, 32'h000F0004);
    reg_wr(ADCRI_OFF_IRQ_CLR, 32'h00010000);
    reg_wr(8'h08, 32'hFFFFFFFF);
    reg_chk(ADCRI_OFF_IRQ_MASK, 32'h000E0004);
    irq_chk(1'b0);
    conv(3'd2, 10'h2F0);
    irq_chk(1'b1);
    reg_chk(ADCRI_OFF_LAST, 32'h2F0);
    irq_chk(1'b0);
    reg_chk(ADCRI_OFF_CH_RES0 + 8'h08, 32'h2F0);
    $display("test interrupt mask done");
    @(posedge clk_sys_i);
    ovr_i <= 8'h81;
    govr_i <= 1'b1;
    @(posedge clk_sys_i);
    ovr_i <= 8'h00;
    govr_i <= 1'b0;
    irq_chk(1'b1);
    reg_chk(ADCRI_OFF_FLAGS, 32'h00028100);
    reg_chk(ADCRI_OFF_FLAGS, 32'h0);
    irq_chk(1'b0);
    $display("test overrun done");
    @(posedge clk_sys_i);
    timer_output_a_i <= 3'b101;
    timer_output_b_i <= 3'b010;
    repeat (3) @(posedge clk_sys_i);
    #1 check_word(32'h19, {26'h0, hw_trig_o});
    $display("test triggers done");
    report_and_stop();
  end
endmodule
